// ### dip_pkg.sv
/*
 * shared constants of the debounced input port block: timing, debounce steps,
 * register offsets and reset values.
 * assumes a 40 mhz aclk and a 32-bit axi4-lite register bus with byte addresses.
 */
package dip_pkg;
   // clock and debounce time base
   localparam int unsigned CLK_HZ = 40_000_000; // aclk rate
   localparam int unsigned TICK_NS = 18_000; // shortest debounce step, ns
   localparam int unsigned TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000; // rounded up
   localparam int unsigned REQ_UNIT_NS = 4_000; // unit of a requested debounce time
   localparam int unsigned NUM_STEPS = 30; // 18 us .. ~9600 s, doubling
   localparam int unsigned STEP_W = 5; // width of a step index
   localparam logic [4:0] STEP_RST = 5'h00; // 18 us after reset
   localparam logic [4:0] STEP_MAX = 5'h1d; // longest step
   localparam logic [34:0] STEP0_HALF_UNITS = 35'h9; // 18 us in 2 us units
   localparam int unsigned DEB_CNT_W = 30; // tick counter per input bit

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00; // [3:0] external clock sel, [11:8] data-available enable
   localparam logic [7:0] OFS_DEB0 = 8'h04; // port 0 debounce (pair 0/1)
   localparam logic [7:0] OFS_DEB1 = 8'h08; // port 1 debounce (pair 0/1)
   localparam logic [7:0] OFS_DEB2 = 8'h0c; // port 2 debounce (pair 2/3)
   localparam logic [7:0] OFS_DEB3 = 8'h10; // port 3 debounce (pair 2/3)
   localparam logic [7:0] OFS_DATA0 = 8'h14; // word reads, ports 0..3
   localparam logic [7:0] OFS_DATA1 = 8'h18;
   localparam logic [7:0] OFS_DATA2 = 8'h1c;
   localparam logic [7:0] OFS_DATA3 = 8'h20;
   localparam logic [7:0] OFS_LONG01 = 8'h24; // paired long word, ports 0/1
   localparam logic [7:0] OFS_LONG23 = 8'h28; // paired long word, ports 2/3
   localparam logic [7:0] OFS_BITSEL = 8'h2c; // [4:0] bit, [6:5] port, [7] long form
   localparam logic [7:0] OFS_BITVAL = 8'h30; // selected bit, 0 or 1
   localparam logic [7:0] OFS_RISE_SEL = 8'h34; // channel select for rising edges
   localparam logic [7:0] OFS_FALL_SEL = 8'h38; // channel select for falling edges
   localparam logic [7:0] OFS_STATUS = 8'h3c; // [3:0] data available, [7:4] rise, [11:8] fall
   localparam logic [7:0] OFS_MASK = 8'h40; // interrupt mask, same layout

   localparam logic [31:0] CTRL_RST = 32'h0000_0000; // internal clock, no data-available events
   localparam logic [31:0] SEL_RST = 32'h0000_0000; // no channel selected
   localparam logic [31:0] MASK_RST = 32'h0000_0000; // all interrupts masked
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### dip_if.sv
/*
 * interfaces between the modules of the debounced input port block:
 * a simple register access port and a debouncer port.
 * assumes everything runs on aclk.
 */
`timescale 1ns/1ps
// register access between the bus slave and the register file
interface dip_reg_if;
   logic wr_en; // one-cycle write strobe
   logic [7:0] wr_addr; // byte address of the write
   logic [31:0] wr_data; // write data
   logic [3:0] wr_strb; // byte enables
   logic wr_err; // write address not writable
   logic rd_en; // one-cycle read strobe, side effects act here
   logic [7:0] rd_addr; // byte address of the read
   logic [31:0] rd_data; // combinational read data
   logic rd_err; // read address unmapped
   modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface // dip_reg_if

// one debouncer serving a pair of ports
interface dip_deb_if #(parameter int W = 32);
   logic tick; // one pulse per 18 us
   logic [4:0] step; // selected debounce step
   logic [W-1:0] raw; // sampled input data
   logic [W-1:0] stable; // debounced data
   modport deb (input tick, step, raw, output stable);
   modport ctl (output tick, step, raw, input stable);
endinterface // dip_deb_if

// ### dip_debounce.sv
/*
 * per-bit debouncer for a pair of 16-bit ports.
 * assumes raw data already synchronised to aclk and a tick from the caller.
 */
`timescale 1ns/1ps
module dip_debounce #(
   parameter int W = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   dip_deb_if.deb d
);
   logic [W-1:0] stable_r; // accepted levels
   logic [dip_pkg::DEB_CNT_W-1:0] cnt_r [W]; // ticks a changed level has held
   logic [dip_pkg::DEB_CNT_W-1:0] limit; // ticks needed at this step

   // step k waits 2^k ticks; doubling steps mean a shift, no table
   assign limit = dip_pkg::DEB_CNT_W'(1) << d.step;

   // a change is taken only after it held for the whole time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stable_r <= '0;
         for (int i = 0; i < W; i++) begin
            cnt_r[i] <= '0;
         end
      end else begin
         for (int i = 0; i < W; i++) begin
            if (d.raw[i] == stable_r[i]) begin
               cnt_r[i] <= '0; // bounce back restarts the wait
            end else if (cnt_r[i] >= limit) begin
               stable_r[i] <= d.raw[i];
               cnt_r[i] <= '0;
            end else if (d.tick) begin
               cnt_r[i] <= cnt_r[i] + 1'b1;
            end
         end
      end
   end

   assign d.stable = stable_r;
endmodule // dip_debounce

// ### dip_axil.sv
/*
 * axi4-lite slave front end: turns bus transfers into register strobes.
 * assumes the register file answers reads combinationally in the same cycle.
 */
`timescale 1ns/1ps
module dip_axil (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   dip_reg_if.bus r
);
   logic aw_full_r; // write address held
   logic w_full_r; // write data held
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic do_wr; // both halves present, perform write

   // one write in flight: no new halves while the answer waits
   assign awready = !aw_full_r && !bvalid_r;
   assign wready = !w_full_r && !bvalid_r;
   assign do_wr = aw_full_r && w_full_r && !bvalid_r;
   assign arready = !rvalid_r;

   // address half, taken in either order with data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         awaddr_r <= 8'h00;
      end else if (awvalid && awready) begin
         aw_full_r <= 1'b1;
         awaddr_r <= awaddr;
      end else if (do_wr) begin
         aw_full_r <= 1'b0;
      end
   end

   // data half
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (wvalid && wready) begin
         w_full_r <= 1'b1;
         wdata_r <= wdata;
         wstrb_r <= wstrb;
      end else if (do_wr) begin
         w_full_r <= 1'b0;
      end
   end

   // write answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= dip_pkg::RESP_OKAY;
      end else if (do_wr) begin
         bvalid_r <= 1'b1;
         bresp_r <= r.wr_err ? dip_pkg::RESP_SLVERR : dip_pkg::RESP_OKAY;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read: data captured at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= dip_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= r.rd_data;
         rresp_r <= r.rd_err ? dip_pkg::RESP_SLVERR : dip_pkg::RESP_OKAY;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign r.wr_en = do_wr;
   assign r.wr_addr = awaddr_r;
   assign r.wr_data = wdata_r;
   assign r.wr_strb = wstrb_r;
   assign r.rd_en = arvalid && arready;
   assign r.rd_addr = araddr;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
endmodule // dip_axil

// ### dip_top.sv
/*
 * four 16-bit debounced input ports with edge and data-available events,
 * reached over axi4-lite.
 * assumes field inputs and the external sample clock are asynchronous pins;
 * all logic runs on aclk.
 */
// Contract
// - thirty doubling debounce steps, 18 us upward
// - requested time rounds to a discrete step
// - ports 0/1 and 2/3 share debounce
// - reset debounce time is 18 us
// - reset selects internal sample clock
// - clock source readable per port
// - word read returns signed port data
// - long word only ports 0/2, pairs next
// - bit read returns 0 or 1
// - independent event detector per port
// - rising transition on selected channel flags
// - falling transition on selected channel flags
// - data-available sets only while enabled
// - reading port data clears data-available
// - debounce and events run on aclk
// - external mode captures on external pulse only
// - data-available only from external sampling
`timescale 1ns/1ps
module dip_top #(
   parameter int unsigned TICK_CYCLES = dip_pkg::TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [63:0] field_in,
   input wire logic external_sample_clock,
   output logic irq
);
   dip_reg_if rif ();
   dip_deb_if #(.W(32)) deb01 ();
   dip_deb_if #(.W(32)) deb23 ();

   logic [64:0] sync1_r, sync2_r, sync3_r; // pins and sample clock, three stages
   logic [64:0] agreed_r; // level once stages two and three agree
   logic smp_clk_prev_r; // previous agreed sample clock level
   logic smp_edge; // rising edge of the external sample clock
   logic [63:0] sampled_r; // data clocked into the debouncers
   logic [63:0] stable; // debounced data of all ports
   logic [63:0] prev_stable_r; // for edge detection
   logic [31:0] ctrl_r; // clock select and data-available enable
   logic [4:0] step01_r, step23_r; // shared debounce steps
   logic [7:0] bitsel_r; // bit read selector
   logic [15:0] rise_sel_r, fall_sel_r; // channels that raise edge events
   logic [11:0] status_r; // sticky events
   logic [11:0] mask_r; // interrupt enables
   logic [11:0] status_set; // events this cycle
   logic [11:0] status_clr; // clears this cycle
   logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_r; // 18 us prescaler
   logic tick; // one pulse per 18 us
   logic [31:0] long_sel; // long word chosen by the bit selector
   logic [31:0] rd_data; // read mux

   // nearest step at or above the request, in 4 us units, saturating
   function automatic logic [4:0] round_step(input logic [31:0] req);
      round_step = dip_pkg::STEP_MAX; // beyond the top rounds down to it
      for (int k = dip_pkg::NUM_STEPS - 1; k >= 0; k--) begin
         if ({1'b0, req, 1'b0} <= (dip_pkg::STEP0_HALF_UNITS << k)) begin
            round_step = 5'(k);
         end
      end
   endfunction

   // byte-lane merge of a register write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
      merge = old;
   endfunction

   dip_axil u_axil (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .r(rif.bus)
   );

   // three-stage synchroniser; a change counts once stages two and three agree
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
         sync3_r <= '0;
         agreed_r <= '0;
      end else begin
         sync1_r <= {external_sample_clock, field_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         agreed_r <= (sync2_r & sync3_r) | (agreed_r & (sync2_r | sync3_r));
      end
   end

   // external sample clock edge, found by aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         smp_clk_prev_r <= 1'b0;
      end else begin
         smp_clk_prev_r <= agreed_r[64];
      end
   end
   assign smp_edge = agreed_r[64] && !smp_clk_prev_r;

   // capture into the debouncers: every cycle, or per external pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sampled_r <= '0;
      end else begin
         for (int p = 0; p < 4; p++) begin
            if (!ctrl_r[p] || smp_edge) begin
               sampled_r[p*16 +: 16] <= agreed_r[p*16 +: 16];
            end
         end
      end
   end

   // 18 us time base; debounce counts these ticks on aclk
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_r <= '0;
      end else if (tick) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick_cnt_r + 1'b1;
      end
   end
   assign tick = (tick_cnt_r == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1));

   // one debouncer per port pair, both on aclk whatever the sample source
   assign deb01.tick = tick;
   assign deb01.step = step01_r;
   assign deb01.raw = sampled_r[31:0];
   assign deb23.tick = tick;
   assign deb23.step = step23_r;
   assign deb23.raw = sampled_r[63:32];
   assign stable = {deb23.stable, deb01.stable};

   dip_debounce #(.W(32)) u_deb01 (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(deb01.deb)
   );

   dip_debounce #(.W(32)) u_deb23 (
      .aclk(aclk),
      .aresetn(aresetn),
      .d(deb23.deb)
   );

   // control: clock source and data-available enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= dip_pkg::CTRL_RST;
      end else if (rif.wr_en && rif.wr_addr == dip_pkg::OFS_CTRL) begin
         ctrl_r <= merge(ctrl_r, rif.wr_data, rif.wr_strb) & 32'h0000_0f0f;
      end
   end

   // shared debounce steps; either port of a pair writes the pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step01_r <= dip_pkg::STEP_RST;
         step23_r <= dip_pkg::STEP_RST;
      end else if (rif.wr_en) begin
         if (rif.wr_addr == dip_pkg::OFS_DEB0 || rif.wr_addr == dip_pkg::OFS_DEB1) begin
            step01_r <= round_step(rif.wr_data);
         end
         if (rif.wr_addr == dip_pkg::OFS_DEB2 || rif.wr_addr == dip_pkg::OFS_DEB3) begin
            step23_r <= round_step(rif.wr_data);
         end
      end
   end

   // bit selector, edge channel selects and interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bitsel_r <= 8'h00;
         rise_sel_r <= dip_pkg::SEL_RST[15:0];
         fall_sel_r <= dip_pkg::SEL_RST[15:0];
         mask_r <= dip_pkg::MASK_RST[11:0];
      end else if (rif.wr_en) begin
         unique case (rif.wr_addr)
            dip_pkg::OFS_BITSEL: bitsel_r <= 8'(merge({24'h0, bitsel_r}, rif.wr_data, rif.wr_strb));
            dip_pkg::OFS_RISE_SEL: rise_sel_r <= 16'(merge({16'h0, rise_sel_r}, rif.wr_data, rif.wr_strb));
            dip_pkg::OFS_FALL_SEL: fall_sel_r <= 16'(merge({16'h0, fall_sel_r}, rif.wr_data, rif.wr_strb));
            dip_pkg::OFS_MASK: mask_r <= 12'(merge({20'h0, mask_r}, rif.wr_data, rif.wr_strb));
            default: ; // other addresses touch none of these
         endcase
      end
   end

   // only writable offsets answer okay
   always_comb begin
      unique case (rif.wr_addr)
         dip_pkg::OFS_CTRL, dip_pkg::OFS_DEB0, dip_pkg::OFS_DEB1, dip_pkg::OFS_DEB2, dip_pkg::OFS_DEB3,
         dip_pkg::OFS_BITSEL, dip_pkg::OFS_RISE_SEL, dip_pkg::OFS_FALL_SEL, dip_pkg::OFS_MASK: rif.wr_err = 1'b0;
         default: rif.wr_err = 1'b1;
      endcase
   end

   // previous debounced data for the edge detectors
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_stable_r <= '0;
      end else begin
         prev_stable_r <= stable;
      end
   end

   // event sources, one detector per port
   always_comb begin
      status_set = '0;
      for (int p = 0; p < 4; p++) begin
         status_set[p] = ctrl_r[p] && ctrl_r[8+p] && smp_edge;
         status_set[4+p] = |(stable[p*16 +: 16] & ~prev_stable_r[p*16 +: 16] & rise_sel_r);
         status_set[8+p] = |(~stable[p*16 +: 16] & prev_stable_r[p*16 +: 16] & fall_sel_r);
      end
   end

   // read-side clears: status read clears all, a data read its data-available bit
   always_comb begin
      status_clr = '0;
      if (rif.rd_en) begin
         unique case (rif.rd_addr)
            dip_pkg::OFS_STATUS: status_clr = 12'hfff;
            dip_pkg::OFS_DATA0: status_clr[0] = 1'b1;
            dip_pkg::OFS_DATA1: status_clr[1] = 1'b1;
            dip_pkg::OFS_DATA2: status_clr[2] = 1'b1;
            dip_pkg::OFS_DATA3: status_clr[3] = 1'b1;
            dip_pkg::OFS_LONG01: status_clr[1:0] = 2'h3;
            dip_pkg::OFS_LONG23: status_clr[3:2] = 2'h3;
            default: ;
         endcase
      end
   end

   // sticky status; an event in the clearing cycle survives
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~status_clr) | status_set;
      end
   end
   assign irq = |(status_r & mask_r);

   // long word the bit selector points at: port 0 or 2 low, next port high
   assign long_sel = bitsel_r[6] ? stable[63:32] : stable[31:0];

   // read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      rif.rd_err = 1'b0;
      unique case (rif.rd_addr)
         dip_pkg::OFS_CTRL: rd_data = ctrl_r;
         dip_pkg::OFS_DEB0, dip_pkg::OFS_DEB1: rd_data = {27'h0, step01_r};
         dip_pkg::OFS_DEB2, dip_pkg::OFS_DEB3: rd_data = {27'h0, step23_r};
         dip_pkg::OFS_DATA0: rd_data = {{16{stable[15]}}, stable[15:0]};
         dip_pkg::OFS_DATA1: rd_data = {{16{stable[31]}}, stable[31:16]};
         dip_pkg::OFS_DATA2: rd_data = {{16{stable[47]}}, stable[47:32]};
         dip_pkg::OFS_DATA3: rd_data = {{16{stable[63]}}, stable[63:48]};
         dip_pkg::OFS_LONG01: rd_data = stable[31:0];
         dip_pkg::OFS_LONG23: rd_data = stable[63:32];
         dip_pkg::OFS_BITSEL: rd_data = {24'h0, bitsel_r};
         dip_pkg::OFS_BITVAL: begin
            // word form ignores index bit 4, so the index stays within 0..15
            if (bitsel_r[7]) begin
               rd_data = {31'h0, long_sel[bitsel_r[4:0]]};
            end else begin
               rd_data = {31'h0, stable[{bitsel_r[6:5], bitsel_r[3:0]}]};
            end
         end
         dip_pkg::OFS_RISE_SEL: rd_data = {16'h0, rise_sel_r};
         dip_pkg::OFS_FALL_SEL: rd_data = {16'h0, fall_sel_r};
         dip_pkg::OFS_STATUS: rd_data = {20'h0, status_r};
         dip_pkg::OFS_MASK: rd_data = {20'h0, mask_r};
         default: rif.rd_err = 1'b1; // unmapped reads answer slverr with zero
      endcase
   end
   assign rif.rd_data = rd_data;
endmodule // dip_top

// ### dip_top_chk_sva.sv
/* bus and reset checks on the debounced input port top.
   assumes one aclk domain and the sync active-low reset. */
`timescale 1ns/1ps
module dip_top_chk #(
   parameter int unsigned TICK_CYCLES = 720
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // answers stand until taken
   chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer moved");
   chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer moved");
   // answers only follow their requests
   chk_ar_block: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
      else $error("read answer without request");
   chk_aw_block: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
      else $error("write answered before both halves");
   // fixed answer latencies
   chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   // refusals
   chk_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h40
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read answered");
   chk_wr_ro: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == dip_pkg::OFS_DATA0 |-> ##2 s_axi_bresp == 2'h2) else $error("data write taken");
   // quiet outputs on leaving reset
   chk_rst_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !irq)
      else $error("busy after reset");
endmodule // dip_top_chk
bind dip_top dip_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_dip_top_chk (.*);

// ### dip_field_src.sv
/* field side partner: input levels and the external sample clock.
   assumes the bench asks for one clock period per toggle of go. */
`timescale 1ns/1ps
module dip_field_src (
   input wire logic [63:0] want,
   input wire logic go,
   output logic [63:0] field_in,
   output logic sample_clk
);
   // levels settle a little after the request, off any edge
   assign #3 field_in = want;
   // clock stands still low between frames
   initial sample_clk = 1'h0;
   // one 200 ns period per request
   always @(go) begin
      #100 sample_clk = 1'h1;
      #100 sample_clk = 1'h0;
   end
endmodule // dip_field_src

// ### debounced_input_port_events_test.sv
/* testbench: register traffic over axi4-lite, field levels from the partner.
   assumes a 4-cycle debounce tick so steps stay short. */
`timescale 1ns/1ps
module debounced_input_port_events_test;
   logic aclk = 1'h0, aresetn = 1'h0; // clock, sync reset
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // addresses
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d; // data, last read
   logic [3:0] s_axi_wstrb = 4'hf; // whole words
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, go = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, external_sample_clock;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs; // last response
   logic [63:0] field_in, want = 64'h0; // pins, requested levels
   int n_errors = 0, checks = 0;
   dip_top #(.TICK_CYCLES(4)) i_dip_top (.*);
   dip_field_src i_dip_field_src (.want(want), .go(go), .field_in(field_in), .sample_clk(external_sample_clock));
   // 40 mhz clock
   initial forever #12.5 aclk = ~aclk;
   task automatic complete_run();
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic ck(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // write: both halves offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      logic ha, hw, hb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(negedge aclk); // pre-edge values, settled
         ha = s_axi_awvalid & s_axi_awready;
         hw = s_axi_wvalid & s_axi_wready;
         hb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ha) s_axi_awvalid <= 1'h0;
         if (hw) s_axi_wvalid <= 1'h0;
         n++;
      end while (!hb && n < 50);
      s_axi_bready <= 1'h0;
      if (!hb) n_errors++;
      if (!hb) complete_run();
   endtask
   // read and compare; the leading edge keeps strobes from double assignment
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      int n = 0;
      logic ha, hb;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(negedge aclk);
         ha = s_axi_arvalid & s_axi_arready;
         hb = s_axi_rvalid;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ha) s_axi_arvalid <= 1'h0;
         n++;
      end while (!hb && n < 50);
      s_axi_rready <= 1'h0;
      if (!hb) n_errors++;
      if (!hb) complete_run();
      ck(d, exp);
   endtask
   task automatic s_reset();
      rd(dip_pkg::OFS_CTRL, dip_pkg::CTRL_RST);
      rd(dip_pkg::OFS_DEB3, 32'h0);
      rd(8'h44, 32'h0);
      ck({30'h0, rs}, 32'h2);
      wr(dip_pkg::OFS_DATA0, 32'h1);
      ck({30'h0, rs}, 32'h2);
   endtask
   task automatic s_deb();
      wr(dip_pkg::OFS_DEB0, 32'h09);
      rd(dip_pkg::OFS_DEB1, 32'h1);
      wr(dip_pkg::OFS_DEB3, 32'hffffffff);
      rd(dip_pkg::OFS_DEB2, 32'h1d);
      wr(dip_pkg::OFS_DEB2, 32'h0);
      wr(dip_pkg::OFS_DEB1, 32'h0a);
   endtask
   // pair 0/1 on step 2: 14..17 cycles of stable level needed
   task automatic s_data();
      want <= 64'h0000_0000_1234_8001;
      repeat (6) @(posedge aclk);
      rd(dip_pkg::OFS_DATA0, 32'h0);
      repeat (30) @(posedge aclk);
      rd(dip_pkg::OFS_DATA0, 32'hffff_8001);
      rd(dip_pkg::OFS_LONG01, 32'h1234_8001);
      wr(dip_pkg::OFS_BITSEL, 32'h9c);
      rd(dip_pkg::OFS_BITVAL, 32'h1);
      wr(dip_pkg::OFS_BITSEL, 32'h01);
      rd(dip_pkg::OFS_BITVAL, 32'h0);
   endtask
   task automatic s_edge();
      wr(dip_pkg::OFS_RISE_SEL, 32'h1);
      wr(dip_pkg::OFS_FALL_SEL, 32'h1);
      wr(dip_pkg::OFS_MASK, 32'h0ff0);
      rd(dip_pkg::OFS_STATUS, 32'h0);
      want[32] <= 1'h1;
      repeat (30) @(negedge aclk);
      ck({31'h0, irq}, 32'h1);
      rd(dip_pkg::OFS_STATUS, 32'h40);
      @(negedge aclk);
      ck({31'h0, irq}, 32'h0);
      want[32] <= 1'h0;
      want[0] <= 1'h0;
      repeat (30) @(posedge aclk);
      rd(dip_pkg::OFS_STATUS, 32'h500);
   endtask
   // port 3 external with data-available, port 2 external without
   task automatic s_dav();
      wr(dip_pkg::OFS_CTRL, 32'h080c);
      rd(dip_pkg::OFS_CTRL, 32'h080c);
      want[63:48] <= 16'h5554;
      repeat (30) @(posedge aclk);
      rd(dip_pkg::OFS_DATA3, 32'h0);
      go <= ~go;
      repeat (30) @(negedge aclk);
      ck({31'h0, irq}, 32'h0);
      rd(dip_pkg::OFS_STATUS, 32'h8);
      go <= ~go;
      repeat (30) @(posedge aclk);
      rd(dip_pkg::OFS_DATA3, 32'h5554);
      rd(dip_pkg::OFS_STATUS, 32'h0);
      rd(dip_pkg::OFS_LONG23, 32'h5554_0000);
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      s_reset();
      s_deb();
      s_data();
      s_edge();
      s_dav();
      complete_run();
   end
endmodule // debounced_input_port_events_test
